// ===== hdl/nsft_top.sv
// no-protocol serial frame transmitter with register port
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "nsft_consts.svh"
module nsft_top
  import nsft_pkg::*;
#(
  parameter int        TICK_CYC  = `NSFT_TICK_MS * `NSFT_CLK_KHZ,
  parameter int        REJ_CYC   = (`NSFT_REJ_US * `NSFT_CLK_KHZ) / 1000,
  parameter logic [7:0] UNIT_ADDR = 8'h10 // arbitrary value
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [15:0] REG_RDATA,
  input  wire logic        CMD_VALID,
  input  wire nsft_req_t   CMD_REQ,
  output logic             CMD_READY,
  output logic             CMD_DONE,
  input  wire logic        UNIT_INIT,
  output logic             SRC_RD,
  output logic      [7:0]  SRC_IDX,
  input  wire logic [15:0] SRC_WORD,
  output logic             TX_VALID,
  output logic      [7:0]  TX_DATA,
  output logic             TX_PORT,
  input  wire logic        TX_READY,
  output logic      [1:0]  RS_OUT,
  output logic      [1:0]  ER_OUT,
  output logic      [1:0]  SEND_READY,
  output logic             ERR_FLAG
);

  ////////////////////////////////////////////////////////////////////////////
  logic           rst_m_r;
  logic           rst_n_r;
  nsft_regs_t     r_r;
  nsft_regs_t     r_nxt;
  nsft_port_cfg_t sel_cfg;
  nsft_port_cfg_t act_cfg;
  logic           acc;
  logic           unit_ok;
  logic           ctl_ok;
  logic           cnt_ok;
  logic           mode_ok;
  logic [3:0]     req_port;
  logic           req_p;
  logic [8:0]     fmt_size;
  logic [8:0]     n_eff;
  logic [7:0]     cur_byte;
  logic           tick;
  logic           busy;

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_m_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n_r <= rst_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request decode
  assign req_port = CMD_REQ.ctrl1[11:8];                           // [RL9]
  assign req_p    = (req_port == `NSFT_PORT2);
  assign sel_cfg  = req_p ? r_r.p2 : r_r.p1;
  assign act_cfg  = r_r.port ? r_r.p2 : r_r.p1;
  assign unit_ok  = (CMD_REQ.ctrl1[7:0] == UNIT_ADDR);
  assign ctl_ok   = (req_port == `NSFT_PORT1 || req_port == `NSFT_PORT2)
                 && (CMD_REQ.ctrl1[15:12] <= `NSFT_MAX_LPORT)
                 && (CMD_REQ.ctrl0[7:4] <= `NSFT_MAX_MODEM)
                 && (CMD_REQ.ctrl0[3:0] <= `NSFT_MAX_ORDER);       // [RL16]
  assign cnt_ok   = (CMD_REQ.count <= `NSFT_MAX_COUNT);             // [RL16]
  assign mode_ok  = r_r.mode[req_p];                                // [RL17]
  assign fmt_size = (sel_cfg.fmt[7:0] == 8'h00) ? `NSFT_FULL_SIZE
                                                : {1'b0, sel_cfg.fmt[7:0]}; // [RL6]
  // the frame size setting caps the payload; the count never adds codes
  assign n_eff    = (CMD_REQ.count[8:0] < fmt_size) ? CMD_REQ.count[8:0]
                                                    : fmt_size;     // [RL10] [RL11]
  assign busy     = (r_r.st != S_IDLE);
  assign acc      = CMD_VALID && (r_r.st == S_IDLE);
  assign tick     = (r_r.div == 18'(TICK_CYC - 1));
  // second byte of the held word, picked by the requested byte order
  assign cur_byte = r_r.order ? r_r.word[7:0] : r_r.word[15:8];    // [RL8]

  assign SEND_READY = {!r_r.init_s && !(busy && r_r.port),
                       !r_r.init_s && !(busy && !r_r.port)};        // [RL7]
  assign CMD_READY = !busy;
  assign CMD_DONE  = r_r.done;
  assign SRC_RD    = (r_r.st == S_FETCH) || (r_r.st == S_MFETCH);
  assign SRC_IDX   = r_r.widx;
  assign TX_VALID  = (r_r.st == S_START) || (r_r.st == S_DATA)
                  || (r_r.st == S_END1) || (r_r.st == S_END2);
  assign TX_DATA   = r_r.txd;
  assign TX_PORT   = r_r.port;
  assign RS_OUT    = r_r.rs;
  assign ER_OUT    = r_r.er;
  assign ERR_FLAG  = r_r.err;
  assign REG_RDATA = r_r.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    r_nxt      = r_r;
    r_nxt.done = 1'b0;
    r_nxt.init_m = UNIT_INIT;
    r_nxt.init_s = r_r.init_m;
    // register port
    if (REG_WR) begin
      case (REG_ADDR)
        `NSFT_OFF_P1_DLY:  r_nxt.p1.dly   = REG_WDATA;
        `NSFT_OFF_P1_CODE: r_nxt.p1.codes = REG_WDATA;
        `NSFT_OFF_P1_FMT:  r_nxt.p1.fmt   = REG_WDATA;
        `NSFT_OFF_P2_DLY:  r_nxt.p2.dly   = REG_WDATA;
        `NSFT_OFF_P2_CODE: r_nxt.p2.codes = REG_WDATA;
        `NSFT_OFF_P2_FMT:  r_nxt.p2.fmt   = REG_WDATA;
        `NSFT_OFF_MODE:    r_nxt.mode     = REG_WDATA[1:0];
        default: ;
      endcase
    end
    r_nxt.rdata = 16'h0000;
    if (REG_RD) begin
      case (REG_ADDR)
        `NSFT_OFF_P1_DLY:  r_nxt.rdata = r_r.p1.dly;
        `NSFT_OFF_P1_CODE: r_nxt.rdata = r_r.p1.codes;
        `NSFT_OFF_P1_FMT:  r_nxt.rdata = r_r.p1.fmt;
        `NSFT_OFF_P1_STAT: r_nxt.rdata[`NSFT_RDY_BIT] = SEND_READY[0]; // [RL7]
        `NSFT_OFF_P2_DLY:  r_nxt.rdata = r_r.p2.dly;
        `NSFT_OFF_P2_CODE: r_nxt.rdata = r_r.p2.codes;
        `NSFT_OFF_P2_FMT:  r_nxt.rdata = r_r.p2.fmt;
        `NSFT_OFF_P2_STAT: r_nxt.rdata[`NSFT_RDY_BIT] = SEND_READY[1]; // [RL7]
        `NSFT_OFF_MODE:    r_nxt.rdata[1:0] = r_r.mode;
        `NSFT_OFF_ERR:     r_nxt.rdata[0] = r_r.err;
        default: ;
      endcase
    end
    // frame engine
    case (r_r.st)
      S_IDLE: begin
        if (acc) begin
          r_nxt.done = 1'b1;
          if (!unit_ok) begin
            // foreign unit: answer only after the full timeout
            r_nxt.done = 1'b0;
            r_nxt.rej  = '0;
            r_nxt.st   = S_REJ;                                     // [RL19]
          end else if (r_r.init_s) begin
            r_nxt.err = 1'b1;                                       // [RL18]
          end else if (!ctl_ok || !cnt_ok) begin
            r_nxt.err = 1'b1;                                       // [RL16]
          end else if (!mode_ok) begin
            r_nxt.err = 1'b1;                                       // [RL17]
          end else if (!SEND_READY[req_p]) begin
            r_nxt.err = 1'b1;                                       // [RL15]
          end else begin
            r_nxt.err    = 1'b0;                                    // [RL18]
            r_nxt.port   = req_p;
            r_nxt.order  = CMD_REQ.ctrl0[0];
            r_nxt.modem  = CMD_REQ.ctrl0[7:4];
            r_nxt.nbytes = n_eff;
            r_nxt.bidx   = '0;
            r_nxt.widx   = '0;
            r_nxt.div    = '0;
            r_nxt.ticks  = sel_cfg.dly[14:0];                       // [RL2]
            if (n_eff != 9'h000) begin                              // [RL14]
              r_nxt.done = 1'b0;
              // start at once, no wait for a later slot
              if (CMD_REQ.ctrl0[7:4] != 4'h0) begin
                r_nxt.st = S_MFETCH;                                // [RL12]
              end else if (sel_cfg.dly[`NSFT_DLY_EN_BIT]) begin
                r_nxt.st = S_DELAY;                                 // [RL1]
              end else if (sel_cfg.fmt[15:12] == `NSFT_SEL_CODE) begin
                r_nxt.txd = sel_cfg.codes[15:8];
                r_nxt.st  = S_START;                                // [RL13]
              end else begin
                r_nxt.st = S_FETCH;                                 // [RL13]
              end
            end
          end
        end
      end
      S_REJ: begin
        r_nxt.rej = r_r.rej + 15'h0001;
        if (r_r.rej == 15'(REJ_CYC - 1)) begin
          r_nxt.err  = 1'b1;                                        // [RL19]
          r_nxt.done = 1'b1;
          r_nxt.st   = S_IDLE;
        end
      end
      S_MFETCH: r_nxt.st = S_MWAIT;
      S_MWAIT: begin
        // modem word is not payload; data begins one word later
        case (r_r.modem)
          4'h1:    r_nxt.rs[r_r.port] = SRC_WORD[15];              // [RL12]
          4'h2:    r_nxt.er[r_r.port] = SRC_WORD[15];              // [RL12]
          default: begin
            r_nxt.rs[r_r.port] = SRC_WORD[15];                     // [RL12]
            r_nxt.er[r_r.port] = SRC_WORD[14];
          end
        endcase
        r_nxt.widx = 8'h01;
        if (act_cfg.dly[`NSFT_DLY_EN_BIT]) begin
          r_nxt.st = S_DELAY;                                       // [RL1]
        end else if (act_cfg.fmt[15:12] == `NSFT_SEL_CODE) begin
          r_nxt.txd = act_cfg.codes[15:8];
          r_nxt.st  = S_START;
        end else begin
          r_nxt.st = S_FETCH;
        end
      end
      S_DELAY: begin
        // 10 ms ticks from the divider; zero ticks falls straight through
        r_nxt.div = tick ? 18'h00000 : r_r.div + 18'h00001;
        if (r_r.ticks == 15'h0000) begin
          if (act_cfg.fmt[15:12] == `NSFT_SEL_CODE) begin
            r_nxt.txd = act_cfg.codes[15:8];
            r_nxt.st  = S_START;                                    // [RL20]
          end else begin
            r_nxt.st = S_FETCH;                                     // [RL20]
          end
        end else if (tick) begin
          r_nxt.ticks = r_r.ticks - 15'h0001;                       // [RL2]
        end
      end
      S_START: begin
        if (TX_READY) begin
          r_nxt.st = S_FETCH;                                       // [RL4] [RL3]
        end
      end
      S_FETCH: r_nxt.st = S_WAITW;
      S_WAITW: begin
        r_nxt.word = SRC_WORD;
        r_nxt.txd  = (r_r.bidx[0] ^ r_r.order) ? SRC_WORD[15:8]
                                               : SRC_WORD[7:0];    // [RL8]
        r_nxt.st   = S_DATA;
      end
      S_DATA: begin
        if (TX_READY) begin
          r_nxt.bidx = r_r.bidx + 9'h001;
          if (r_r.bidx + 9'h001 == r_r.nbytes) begin
            case (act_cfg.fmt[11:8])
              `NSFT_SEL_CODE: begin
                r_nxt.txd = act_cfg.codes[7:0];                     // [RL5] [RL3]
                r_nxt.st  = S_END1;
              end
              `NSFT_SEL_CRLF: begin
                r_nxt.txd = `NSFT_CR;                               // [RL5]
                r_nxt.st  = S_END1;
              end
              default: begin
                r_nxt.done = 1'b1;
                r_nxt.st   = S_IDLE;
              end
            endcase
          end else if (r_r.bidx[0]) begin
            r_nxt.widx = r_r.widx + 8'h01;
            r_nxt.st   = S_FETCH;
          end else begin
            r_nxt.txd = cur_byte;                                   // [RL8]
          end
        end
      end
      S_END1: begin
        if (TX_READY) begin
          if (act_cfg.fmt[11:8] == `NSFT_SEL_CRLF) begin
            r_nxt.txd = `NSFT_LF;                                   // [RL5] [RL11]
            r_nxt.st  = S_END2;
          end else begin
            r_nxt.done = 1'b1;
            r_nxt.st   = S_IDLE;
          end
        end
      end
      S_END2: begin
        if (TX_READY) begin
          r_nxt.done = 1'b1;
          r_nxt.st   = S_IDLE;
        end
      end
      default: r_nxt.st = S_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!rst_n_r);

  sequence s_good_acc;
    acc && unit_ok && !r_r.init_s && ctl_ok && cnt_ok && mode_ok
      && SEND_READY[req_p];
  endsequence

  sequence s_plain_start;
    s_good_acc ##0 (n_eff != 9'h000) && (CMD_REQ.ctrl0[7:4] == 4'h0)
      && !sel_cfg.dly[`NSFT_DLY_EN_BIT];
  endsequence

  a_ready_busy: assert property (                                   // [RL7]
    (busy && !r_r.port) |-> !SEND_READY[0]
      && !(REG_RD && REG_ADDR == `NSFT_OFF_P1_STAT && r_nxt.rdata[`NSFT_RDY_BIT]))
    else $error("port 1 ready while busy");

  a_zero_silent: assert property (                                  // [RL14]
    (s_good_acc ##0 n_eff == 9'h000) |=> !TX_VALID [*3])
    else $error("zero count produced output");

  a_bad_count: assert property (                                    // [RL16]
    (acc && unit_ok && !cnt_ok) |=> ERR_FLAG && CMD_DONE)
    else $error("bad count not flagged");

  a_ok_clears: assert property (                                    // [RL18]
    s_good_acc |=> !ERR_FLAG)
    else $error("accepted request left error set");

  a_init_rejects: assert property (                                 // [RL18]
    (acc && unit_ok && r_r.init_s) |=> ERR_FLAG && !busy)
    else $error("request taken while initializing");

  a_mode_rejects: assert property (                                 // [RL17]
    (acc && unit_ok && !r_r.init_s && ctl_ok && cnt_ok && !mode_ok)
      |=> ERR_FLAG && !busy)
    else $error("non-protocol port accepted");

  a_start_first: assert property (                                  // [RL4]
    (s_plain_start ##0 sel_cfg.fmt[15:12] == `NSFT_SEL_CODE)
      |=> TX_VALID && TX_DATA == $past(sel_cfg.codes[15:8]))
    else $error("start byte not sent first");

  a_fetch_now: assert property (                                    // [RL13]
    (s_plain_start ##0 sel_cfg.fmt[15:12] == `NSFT_SEL_NONE) |=> SRC_RD)
    else $error("transmit did not start at once");

  a_crlf_pair: assert property (                                    // [RL5]
    (r_r.st == S_END1 && TX_READY && TX_DATA == `NSFT_CR
      && act_cfg.fmt[11:8] == `NSFT_SEL_CRLF)
      |=> TX_VALID && TX_DATA == `NSFT_LF)
    else $error("line feed missing after carriage return");

  a_unit_wait: assert property (                                    // [RL19]
    (acc && !unit_ok) |=> (busy && $stable(ERR_FLAG)) [*8])
    else $error("foreign unit rejected too early");

  a_delay_quiet: assert property (                                  // [RL20]
    (r_r.st == S_DELAY && r_r.ticks != 15'h0000) |=> !TX_VALID)
    else $error("byte sent during send delay");

endmodule

// ===== hdl/nsft_consts.svh
// constants for the no-protocol serial frame transmitter
// Overview of operation
// (RL1) delay word bit 15 enables send delay
// (RL2) delay bits 0-14 in 10 ms units
// (RL3) codes word: start high byte, end low
// (RL4) format bits 12-15: 1 prepends start byte
// (RL5) format bits 8-11: end byte or CR+LF
// (RL6) format bits 0-7 size, 00 means 256
// (RL7) status bit 04 shows per-port send ready
// (RL8) payload bytes sent unchanged on chosen port
// (RL9) second control word: unit, port, logical port
// (RL10) count covers payload only, codes added around
// (RL11) frame at most 259 bytes
// (RL12) first source word bits drive RS/ER lines
// (RL13) sending starts right after acceptance
// (RL14) zero byte count sends nothing
// (RL15) request while not ready sets error
// (RL16) bad count or control word sets error
// (RL17) port not in no-protocol mode sets error
// (RL18) initializing unit rejects; success clears error
// (RL19) foreign unit rejected after up to 1 ms
// (RL20) enabled delay precedes first frame byte
`ifndef NSFT_CONSTS_SVH
`define NSFT_CONSTS_SVH
`define NSFT_OFF_P1_DLY  8'h02
`define NSFT_OFF_P1_CODE 8'h04
`define NSFT_OFF_P1_FMT  8'h05
`define NSFT_OFF_P1_STAT 8'h09
`define NSFT_OFF_P2_DLY  8'h0c
`define NSFT_OFF_P2_CODE 8'h0e
`define NSFT_OFF_P2_FMT  8'h0f
`define NSFT_OFF_P2_STAT 8'h13
`define NSFT_OFF_MODE    8'h18
`define NSFT_OFF_ERR     8'h19
`define NSFT_DLY_EN_BIT  15
`define NSFT_RDY_BIT     4
`define NSFT_MAX_COUNT   16'h0100
`define NSFT_FULL_SIZE   9'h100
`define NSFT_CR          8'h0d
`define NSFT_LF          8'h0a
`define NSFT_SEL_NONE    4'h0
`define NSFT_SEL_CODE    4'h1
`define NSFT_SEL_CRLF    4'h2
`define NSFT_MAX_MODEM   4'h3
`define NSFT_MAX_ORDER   4'h1
`define NSFT_MAX_LPORT   4'h7
`define NSFT_PORT1       4'h1
`define NSFT_PORT2       4'h2
`define NSFT_TICK_MS     10
`define NSFT_REJ_US      1000
`define NSFT_CLK_KHZ     25000
`endif

// ===== hdl/nsft_pkg.sv
// types for the no-protocol serial frame transmitter
package nsft_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_REJ, S_MFETCH, S_MWAIT, S_DELAY, S_START,
    S_FETCH, S_WAITW, S_DATA, S_END1, S_END2
  } nsft_state_t;

  typedef struct packed {
    logic [15:0] ctrl0;
    logic [15:0] ctrl1;
    logic [15:0] count;
  } nsft_req_t;

  typedef struct packed {
    logic [15:0] dly;
    logic [15:0] codes;
    logic [15:0] fmt;
  } nsft_port_cfg_t;

  typedef struct packed {
    nsft_state_t    st;
    nsft_port_cfg_t p1;
    nsft_port_cfg_t p2;
    logic [1:0]     mode;
    logic           err;
    logic           done;
    logic           init_m;
    logic           init_s;
    logic [15:0]    word;
    logic [7:0]     widx;
    logic [8:0]     bidx;
    logic [8:0]     nbytes;
    logic           order;
    logic [3:0]     modem;
    logic           port;
    logic [14:0]    ticks;
    logic [17:0]    div;
    logic [14:0]    rej;
    logic [7:0]     txd;
    logic [1:0]     rs;
    logic [1:0]     er;
    logic [15:0]    rdata;
  } nsft_regs_t;
endpackage

// ===== test/nsft_ext_sink.sv
// far-side serial device model: takes frame bytes, can stall
`timescale 1ns/1ps
module nsft_ext_sink (
  input  wire logic       clk,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_port,
  output logic            tx_ready
);
  logic [8:0] got[$];
  logic       ph;
  initial begin
    tx_ready = 1'b0;
    ph = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // slow mode stalls every other cycle so the byte must be held
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready) got.push_back({tx_port, tx_data});
    ph <= ~ph;
    tx_ready <= slow ? ph : 1'b1;
  end
endmodule

// ===== test/test_noprotocol_serial_frame_tx.sv
// self-checking bench for the no-protocol serial frame transmitter
`timescale 1ns/1ps
`include "nsft_consts.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module test_noprotocol_serial_frame_tx
  import nsft_pkg::*;
;
  // short tick and reject counts keep the run brief
  localparam int          TICK = 10;
  localparam int          REJ  = 12;
  localparam logic [7:0]  UADR = 8'h10; // arbitrary unit address
  localparam logic [15:0] C1P1 = {8'h31, UADR};
  localparam logic [15:0] C1P2 = {8'h32, UADR};
  typedef struct packed {
    logic        p;
    logic        slow;
    logic [15:0] dly;
    logic [15:0] codes;
    logic [15:0] fmt;
    logic [15:0] cnt;
    logic [3:0]  ord;
    logic [3:0]  mdm;
  } nsft_row_t;
  localparam nsft_row_t ROWS [6] = '{
    '{1'b0, 1'b0, 16'h0000, 16'h3b81, 16'h1200, 16'h0002, 4'h0, 4'h0},
    '{1'b0, 1'b1, 16'h0000, 16'h3b81, 16'h1200, 16'h0100, 4'h1, 4'h0},
    '{1'b1, 1'b0, 16'h0000, 16'hc4e7, 16'h0105, 16'h0009, 4'h1, 4'h1},
    '{1'b1, 1'b1, 16'h8002, 16'hc4e7, 16'h1000, 16'h0001, 4'h0, 4'h3},
    '{1'b0, 1'b0, 16'h0005, 16'h3b81, 16'h0000, 16'h0003, 4'h0, 4'h2},
    '{1'b1, 1'b0, 16'h0000, 16'h00ff, 16'h12ff, 16'h00ff, 4'h0, 4'h0}};
  localparam logic [47:0] BADS [6] = '{
    {16'h0000, 8'h31, UADR, 16'h0101},
    {16'h0002, 8'h31, UADR, 16'h0001},
    {16'h0040, 8'h31, UADR, 16'h0001},
    {16'h0000, 8'h33, UADR, 16'h0001},
    {16'h0000, 8'h81, UADR, 16'h0001},
    {16'h0000, 8'h30, UADR, 16'h0001}};
  localparam logic [7:0] RW_OFF [6] = '{`NSFT_OFF_P1_DLY, `NSFT_OFF_P1_CODE,
    `NSFT_OFF_P1_FMT, `NSFT_OFF_P2_DLY, `NSFT_OFF_P2_CODE, `NSFT_OFF_P2_FMT};

  logic        sys_clk;
  logic        resetn    = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr_s  = 1'b0;
  logic        reg_rd_s  = 1'b0;
  logic        cmd_valid = 1'b0;
  nsft_req_t   cmd_req   = '0;
  logic        unit_init = 1'b0;
  logic [15:0] src_word  = 16'h0000;
  logic        slow      = 1'b0;
  logic [1:0]  exp_rs    = 2'b00;
  logic [1:0]  exp_er    = 2'b00;
  logic [15:0] reg_rdata;
  logic        cmd_ready;
  logic        cmd_done;
  logic        src_rd;
  logic [7:0]  src_idx;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        tx_port;
  logic        tx_ready;
  logic [1:0]  rs_out;
  logic [1:0]  er_out;
  logic [1:0]  send_ready;
  logic        err_flag;
  logic [15:0] v;
  logic [8:0]  exp_q[$];
  int          bad_count = 0;
  int          n_tests   = 0;
  int          cyc       = 0;
  int          lat;
  int          dl;

  nsft_top #(.TICK_CYC(TICK), .REJ_CYC(REJ), .UNIT_ADDR(UADR)) dut (
    .SYS_CLK(sys_clk), .RESETN(resetn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr_s), .REG_RD(reg_rd_s), .REG_RDATA(reg_rdata), .CMD_VALID(cmd_valid),
    .CMD_REQ(cmd_req), .CMD_READY(cmd_ready), .CMD_DONE(cmd_done), .UNIT_INIT(unit_init),
    .SRC_RD(src_rd), .SRC_IDX(src_idx), .SRC_WORD(src_word), .TX_VALID(tx_valid),
    .TX_DATA(tx_data), .TX_PORT(tx_port), .TX_READY(tx_ready), .RS_OUT(rs_out),
    .ER_OUT(er_out), .SEND_READY(send_ready), .ERR_FLAG(err_flag));
  nsft_ext_sink sink (.clk(sys_clk), .slow(slow), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_port(tx_port), .tx_ready(tx_ready));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] word_of(input int k);
    return {8'(k) ^ 8'ha5, 8'(k)};
  endfunction
  // source word valid only the cycle after the strobe, scrambled otherwise
  always @(posedge sys_clk) src_word <= src_rd ? word_of(int'(src_idx)) : ~src_word;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_s <= 1'b1;
    @(posedge sys_clk);
    reg_wr_s <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd_s <= 1'b1;
    @(posedge sys_clk);
    reg_rd_s <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
    @(posedge sys_clk);
  endtask
  task automatic cmd(input logic [15:0] c0, input logic [15:0] c1, input logic [15:0] n);
    int k;
    lat = -1;
    cmd_valid <= 1'b1;
    cmd_req <= '{ctrl0: c0, ctrl1: c1, count: n};
    do @(negedge sys_clk); while (cmd_ready !== 1'b1);
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    for (k = 1; k < 2000; k++) begin
      @(negedge sys_clk);
      if (lat < 0 && tx_valid === 1'b1) lat = k;
      if (cmd_done === 1'b1) break;
    end
    dl = k;
    @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic run_row(input nsft_row_t r);
    int n;
    int mn;
    logic [15:0] w;
    slow <= r.slow;
    reg_wr(r.p ? `NSFT_OFF_P2_DLY : `NSFT_OFF_P1_DLY, r.dly);
    reg_wr(r.p ? `NSFT_OFF_P2_CODE : `NSFT_OFF_P1_CODE, r.codes);
    reg_wr(r.p ? `NSFT_OFF_P2_FMT : `NSFT_OFF_P1_FMT, r.fmt);
    exp_q = {};
    n = (r.fmt[7:0] == 8'h00) ? 256 : int'(r.fmt[7:0]);
    if (int'(r.cnt) < n) n = int'(r.cnt);
    if (r.fmt[15:12] == 4'h1) exp_q.push_back({r.p, r.codes[15:8]});
    for (int i = 0; i < n; i++) begin
      w = word_of((i >> 1) + int'(r.mdm != 4'h0));
      exp_q.push_back({r.p, (i[0] ^ r.ord[0]) ? w[15:8] : w[7:0]});
    end
    if (r.fmt[11:8] == 4'h1) exp_q.push_back({r.p, r.codes[7:0]});
    if (r.fmt[11:8] == 4'h2) exp_q.push_back({r.p, `NSFT_CR});
    if (r.fmt[11:8] == 4'h2) exp_q.push_back({r.p, `NSFT_LF});
    w = word_of(0);
    if (r.mdm == 4'h1 || r.mdm == 4'h3) exp_rs[r.p] = w[15];
    if (r.mdm == 4'h2) exp_er[r.p] = w[15];
    if (r.mdm == 4'h3) exp_er[r.p] = w[14];
    sink.got.delete();
    cmd({8'h00, r.mdm, r.ord}, r.p ? C1P2 : C1P1, r.cnt);
    `CHK("frame_len", exp_q.size(), sink.got.size())
    foreach (exp_q[i]) `CHK("frame_byte", exp_q[i], sink.got[i])
    // start code shows at once, data after fetch and wait; modem word adds two
    mn = ((r.fmt[15:12] == 4'h1) ? 1 : 3) + ((r.mdm != 4'h0) ? 2 : 0);
    if (r.dly[15]) mn = mn + TICK * int'(r.dly[14:0]) + 1;
    `CHK("start_lat", mn, lat)
    `CHK("modem", {exp_rs, exp_er}, {rs_out, er_out})
    `CHK("ok_err", 1'b0, err_flag)
    reg_rd(r.p ? `NSFT_OFF_P2_STAT : `NSFT_OFF_P1_STAT, v);
    `CHK("status", 16'h0010, v)
    `CHK("cmd_ready", 1'b1, cmd_ready)
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("rst_ready", 2'b11, send_ready)
    `CHK("rst_err", 1'b0, err_flag)
    @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    foreach (RW_OFF[i]) begin
      reg_rd(RW_OFF[i], v);
      `CHK("cfg_rst", 16'h0000, v)
      reg_wr(RW_OFF[i], 16'ha55a ^ 16'(i));
      reg_rd(RW_OFF[i], v);
      `CHK("cfg_rw", 16'ha55a ^ 16'(i), v)
    end
    reg_wr(`NSFT_OFF_P1_STAT, 16'hffff);
    reg_wr(8'h30, 16'hffff);
    reg_rd(`NSFT_OFF_P1_STAT, v);
    `CHK("stat_ro", 16'h0010, v)
    reg_rd(8'h30, v);
    `CHK("unmapped", 16'h0000, v)
    sink.got.delete();
    // mode register resets with both ports outside no-protocol mode
    cmd(16'h0000, C1P1, 16'h0001);
    `CHK("mode_err", 1'b1, err_flag)
    reg_wr(`NSFT_OFF_MODE, 16'h0001);
    cmd(16'h0000, C1P1, 16'h0000);
    `CHK("zero_err", 1'b0, err_flag)
    cmd(16'h0000, C1P2, 16'h0001);
    `CHK("mode2_err", 1'b1, err_flag)
    reg_rd(`NSFT_OFF_ERR, v);
    `CHK("err_reg", 16'h0001, v)
    reg_wr(`NSFT_OFF_MODE, 16'h0003);
    foreach (BADS[i]) begin
      cmd(16'h0000, C1P1, 16'h0000);
      `CHK("clr_err", 1'b0, err_flag)
      cmd(BADS[i][47:32], BADS[i][31:16], BADS[i][15:0]);
      `CHK("bad_err", 1'b1, err_flag)
      `CHK("bad_done", 1, dl)
    end
    unit_init <= 1'b1;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("init_rdy", 2'b00, send_ready)
    @(posedge sys_clk);
    reg_rd(`NSFT_OFF_P2_STAT, v);
    `CHK("init_stat", 16'h0000, v)
    cmd(16'h0000, C1P1, 16'h0001);
    `CHK("init_err", 1'b1, err_flag)
    unit_init <= 1'b0;
    repeat (4) @(posedge sys_clk);
    cmd(16'h0000, C1P1, 16'h0000);
    cmd(16'h0000, {8'h31, UADR + 8'h01}, 16'h0001);
    `CHK("foreign_wait", 1'b1, dl >= REJ && dl <= REJ + 1)
    `CHK("foreign_err", 1'b1, err_flag)
    `CHK("no_output", 0, sink.got.size())
    foreach (ROWS[i]) run_row(ROWS[i]);
    stop_test();
  end
endmodule
